// ==== core/oms_ctrl.sv ====
// host-side controller driving the pins of a 32k x 8 one-time-programmable memory
// assumes the testbench resolves the data wire from O_DATA and O_DATA_OE_N
// assumes requests come from logic on I_REF_CLK and I_DATA comes from the pins

// Function
// - whole byte driven in parallel while programming
// - 100 us select pulses, repeated until the location verifies
// - at most 25 pulses per address
// - final read-back under normal read conditions
// - verify reads with programming supply still raised
// - identify level on O_IDENT_EN, step bit 0
// - other address lines low while identifying
// - gate used as read strobe, no contention
module oms_ctrl
    import oms_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_RESET_N,
    input wire logic I_REQ_VALID,
    input wire oms_req_t I_REQ,
    output logic O_REQ_READY,
    output logic O_RSP_VALID,
    output oms_rsp_t O_RSP,
    output logic [ADDR_W-1:0] O_ADDR,
    output logic [DATA_W-1:0] O_DATA,
    output logic O_DATA_OE_N,
    input wire logic [DATA_W-1:0] I_DATA,
    output logic O_SELECT_N,
    output logic O_GATE_N,
    output logic O_PROG_EN,
    output logic O_IDENT_EN
);

    // ****************************************
    // helpers
    // ****************************************
    // true for the command that raises the programming supply
    function automatic logic is_prog(input oms_cmd_t c);
        return (c == CMD_PROGRAM);
    endfunction

    // true when a byte holds an odd number of ones
    function automatic logic odd_parity(input logic [DATA_W-1:0] b);
        return ^b;
    endfunction

    // ****************************************
    // declarations
    // ****************************************
    logic rst_meta_q;
    logic rst_sync_n_q;
    logic [DATA_W-1:0] din_meta_q;
    logic [DATA_W-1:0] din_sync_q;
    oms_state_t state_q;
    oms_state_t state_d;
    oms_req_t req_q;
    oms_req_t req_d;
    logic [PCNT_W-1:0] pcnt_q;
    logic [PCNT_W-1:0] pcnt_d;
    logic rsp_valid_q;
    logic rsp_valid_d;
    oms_rsp_t rsp_q;
    oms_rsp_t rsp_d;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic [DATA_W-1:0] dout_q;
    logic [DATA_W-1:0] dout_d;
    logic dout_oe_n_q;
    logic dout_oe_n_d;
    logic sel_n_q;
    logic sel_n_d;
    logic gate_n_q;
    logic gate_n_d;
    logic prog_q;
    logic prog_d;
    logic ident_q;
    logic ident_d;
    logic tmr_load;
    logic [TMR_W-1:0] tmr_count;
    logic tmr_expired;
    logic verified;
    logic [TMR_W-1:0] low_len_q;
    logic [TMR_W-1:0] low_len_d;

    // ****************************************
    // synchronisers
    // ****************************************
    // reset asserts at once and releases two edges later
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rst_meta_q <= 1'b0;
            rst_sync_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n_q <= rst_meta_q;
        end
    end

    // data pins come from outside, only the second stage is read
    always_ff @(posedge I_REF_CLK or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            din_meta_q <= ERASED_BYTE;
            din_sync_q <= ERASED_BYTE;
        end else begin
            din_meta_q <= I_DATA;
            din_sync_q <= din_meta_q;
        end
    end

    // ****************************************
    // interval timer
    // ****************************************
    // reload whenever a timed state is entered
    assign tmr_load = (state_d != state_q) && (state_d != ST_IDLE);

    // length of each timed state
    always_comb begin
        tmr_count = TMR_W'(TURN_CYC);
        unique case (state_d)
            ST_SETUP: tmr_count = TMR_W'(SETUP_CYC);
            ST_PULSE: tmr_count = TMR_W'(PULSE_CYC);
            ST_SAMPLE: tmr_count = TMR_W'(SAMPLE_CYC);
            default: tmr_count = TMR_W'(TURN_CYC);
        endcase
    end

    oms_timer i_timer (
        .i_clk(I_REF_CLK),
        .i_rst_n(rst_sync_n_q),
        .i_load(tmr_load),
        .i_count(tmr_count),
        .o_expired(tmr_expired)
    );

    // ****************************************
    // sequencer
    // ****************************************
    // sampled byte against the byte asked for
    assign verified = (din_sync_q == req_q.data);

    // next state, pulse count and response
    always_comb begin
        state_d = state_q;
        req_d = req_q;
        pcnt_d = pcnt_q;
        rsp_valid_d = 1'b0;
        rsp_d = rsp_q;
        unique case (state_q)
            ST_IDLE: begin
                if (I_REQ_VALID) begin
                    req_d = I_REQ;
                    pcnt_d = '0;
                    state_d = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (tmr_expired) begin
                    if (is_prog(req_q.cmd)) begin
                        pcnt_d = pcnt_q + PCNT_W'(1);
                        state_d = ST_PULSE;
                    end else begin
                        state_d = ST_TURN;
                    end
                end
            end
            ST_PULSE: begin
                if (tmr_expired) begin
                    state_d = ST_TURN;
                end
            end
            ST_TURN: begin
                if (tmr_expired) begin
                    state_d = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (tmr_expired) begin
                    // another pulse only while under the limit
                    if (is_prog(req_q.cmd) && !verified && (pcnt_q < PCNT_W'(MAX_PULSES))) begin
                        state_d = ST_SETUP;
                    end else begin
                        state_d = ST_IDLE;
                        rsp_valid_d = 1'b1;
                        rsp_d.data = din_sync_q;
                        rsp_d.ident = (req_q.cmd == CMD_IDENTIFY) ? din_sync_q : '0;
                        rsp_d.pulses = pcnt_q;
                        unique case (req_q.cmd)
                            CMD_PROGRAM: rsp_d.fail = !verified;
                            CMD_CHECK: rsp_d.fail = !verified;
                            CMD_IDENTIFY: rsp_d.fail = !odd_parity(din_sync_q);
                            CMD_READ: rsp_d.fail = 1'b0;
                        endcase
                    end
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge I_REF_CLK or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            state_q <= ST_IDLE;
            req_q <= '0;
            pcnt_q <= '0;
            rsp_valid_q <= 1'b0;
            rsp_q <= '0;
        end else begin
            state_q <= state_d;
            req_q <= req_d;
            pcnt_q <= pcnt_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_q <= rsp_d;
        end
    end

    // ****************************************
    // pin drive
    // ****************************************
    // pins follow the next state so they line up with it
    always_comb begin
        prog_d = 1'b0;
        ident_d = 1'b0;
        addr_d = addr_q;
        dout_d = req_d.data;
        if (state_d != ST_IDLE) begin
            prog_d = is_prog(req_d.cmd);
            ident_d = (req_d.cmd == CMD_IDENTIFY);
            addr_d = ident_d ? ADDR_W'(req_d.addr[ID_SEL_BIT]) : req_d.addr;
        end
        // data held through the turn so the pulse edge sees it
        dout_oe_n_d = !(prog_d && ((state_d == ST_SETUP) || (state_d == ST_PULSE) || (state_d == ST_TURN)));
        // select low only for the pulse or for a plain read
        sel_n_d = !((state_d == ST_PULSE) ||
                    (!prog_d && ((state_d == ST_TURN) || (state_d == ST_SAMPLE))));
        gate_n_d = !(state_d == ST_SAMPLE);
    end

    always_ff @(posedge I_REF_CLK or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            addr_q <= '0;
            dout_q <= '0;
            dout_oe_n_q <= 1'b1;
            sel_n_q <= 1'b1;
            gate_n_q <= 1'b1;
            prog_q <= 1'b0;
            ident_q <= 1'b0;
        end else begin
            addr_q <= addr_d;
            dout_q <= dout_d;
            dout_oe_n_q <= dout_oe_n_d;
            sel_n_q <= sel_n_d;
            gate_n_q <= gate_n_d;
            prog_q <= prog_d;
            ident_q <= ident_d;
        end
    end

    // outputs
    assign O_REQ_READY = (state_q == ST_IDLE);
    assign O_RSP_VALID = rsp_valid_q;
    assign O_RSP = rsp_q;
    assign O_ADDR = addr_q;
    assign O_DATA = dout_q;
    assign O_DATA_OE_N = dout_oe_n_q;
    assign O_SELECT_N = sel_n_q;
    assign O_GATE_N = gate_n_q;
    assign O_PROG_EN = prog_q;
    assign O_IDENT_EN = ident_q;

    // ****************************************
    // assertions
    // ****************************************
    // length of the current programming pulse in cycles
    always_comb begin
        low_len_d = (!O_SELECT_N && O_PROG_EN) ? low_len_q + TMR_W'(1) : '0;
    end

    always_ff @(posedge I_REF_CLK or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            low_len_q <= '0;
        end else begin
            low_len_q <= low_len_d;
        end
    end

    default clocking cb_ref @(posedge I_REF_CLK);
    endclocking
    default disable iff (!rst_sync_n_q);

    sequence s_pulse_low;
        !O_SELECT_N && O_PROG_EN;
    endsequence

    sequence s_pulse_end;
        $rose(O_SELECT_N) && O_PROG_EN;
    endsequence

    AST_PULSE_WIDTH: assert property (s_pulse_end |-> (low_len_q == TMR_W'(PULSE_CYC)))
        else $error("program pulse width wrong");
    AST_PULSE_STABLE: assert property (s_pulse_low |-> O_GATE_N && !O_DATA_OE_N && $stable(O_ADDR) && $stable(O_DATA))
        else $error("pulse without stable gate, address or data");
    AST_DRIVE_GATE_HIGH: assert property (!O_DATA_OE_N |-> O_GATE_N && O_PROG_EN)
        else $error("data driven while gate low");
    AST_IDENT_ADDR: assert property (O_IDENT_EN |-> (O_ADDR[ADDR_W-1:1] == '0) && !O_PROG_EN)
        else $error("identify with upper address lines set");
    AST_VERIFY_MODE: assert property ((state_q == ST_SAMPLE) && is_prog(req_q.cmd) |-> O_PROG_EN && !O_GATE_N)
        else $error("verify without supply or gate");
    AST_CHECK_NORMAL: assert property ((state_q == ST_SAMPLE) && (req_q.cmd == CMD_CHECK) |-> !O_PROG_EN && !O_IDENT_EN)
        else $error("check read not under normal conditions");
    AST_PULSE_LIMIT: assert property (O_RSP_VALID |-> (O_RSP.pulses <= PCNT_W'(MAX_PULSES)))
        else $error("too many program pulses");
    AST_RSP_ONE: assert property (O_RSP_VALID |=> !O_RSP_VALID)
        else $error("response valid longer than one cycle");

endmodule

// ==== inc/oms_pkg.sv ====
// package of constants and carrier types for the memory mode controller
// assumes a 40 MHz reference clock and one attached one-time-programmable part
package oms_pkg;

    // ****************************************
    // array geometry
    // ****************************************
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;
    localparam int ID_SEL_BIT = 0;
    localparam int PARITY_BIT = 7;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 40;
    localparam int CLK_NS = 25;
    localparam int PULSE_US = 100;
    localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
    localparam int ACCESS_NS = 150;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_NS = 50;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_STAGES = 2;
    localparam int SAMPLE_CYC = ACCESS_CYC + SYNC_STAGES + 1;
    localparam int TURN_CYC = 1;
    localparam int MAX_PULSES = 25;
    localparam int TMR_W = 12;
    localparam int PCNT_W = 5;

    // ****************************************
    // commands and states
    // ****************************************
    typedef enum logic [1:0] {
        CMD_READ = 2'h0,
        CMD_PROGRAM = 2'h1,
        CMD_IDENTIFY = 2'h2,
        CMD_CHECK = 2'h3
    } oms_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SETUP = 3'h1,
        ST_PULSE = 3'h3,
        ST_TURN = 3'h2,
        ST_SAMPLE = 3'h6
    } oms_state_t;

    typedef struct packed {
        oms_cmd_t cmd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } oms_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] ident;
        logic [PCNT_W-1:0] pulses;
        logic fail;
    } oms_rsp_t;

endpackage

// ==== core/oms_timer.sv ====
// down counter that flags when a loaded interval has run out
// assumes a synchronous caller that reloads it on every wait it starts
module oms_timer
    import oms_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_load,
    input wire logic [TMR_W-1:0] i_count,
    output logic o_expired
);

    logic [TMR_W-1:0] cnt_q;
    logic [TMR_W-1:0] cnt_d;

    // ****************************************
    // count
    // ****************************************
    // loading n makes expiry visible exactly n cycles later
    always_comb begin
        cnt_d = cnt_q;
        if (i_load) begin
            cnt_d = i_count - TMR_W'(1);
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - TMR_W'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign o_expired = (cnt_q == '0);

endmodule

// ==== testbench/oms_rom.sv ====
// pin-level model of the one-time-programmable memory at the far side
// assumes the bench resolves the data wire and gives digital mode qualifiers
module oms_rom
    import oms_pkg::*;
#(
    parameter logic [DATA_W-1:0] MAKER_ID = 8'h3e, // arbitrary value
    parameter logic [DATA_W-1:0] PART_ID = 8'h9b // arbitrary value
)
(
    input wire logic [ADDR_W-1:0] i_a,
    input wire logic [DATA_W-1:0] i_d,
    input wire logic [3:0] i_c,
    output logic [DATA_W-1:0] o_q,
    output logic o_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] m [2**ADDR_W];
    int hits [int];
    realtime t_fall;
    initial foreach (m[i]) m[i] = ERASED_BYTE;
    // i_c is select_n, gate_n, program, identify
    always @(negedge i_c[3]) t_fall = $realtime;
    // full-width pulse programs; upper-half cells are weak and need a second one
    always @(posedge i_c[3]) begin
        if (i_c[2] && i_c[1] && (($realtime - t_fall) >= PULSE_US * 1us)) begin
            hits[i_a] = hits.exists(i_a) ? hits[i_a] + 1 : 1;
            if (!i_a[ADDR_W-1] || (hits[i_a] > 1)) m[i_a] = m[i_a] & i_d;
        end
    end
    assign o_oe_n = i_c[2] | (i_c[3] & !i_c[1]);
    // odd-parity identifier codes
    assign o_q = i_c[0] ? (i_a[0] ? PART_ID : MAKER_ID) : m[i_a];
endmodule

// ==== testbench/oms_ctrl_tb.sv ====
// self-checking bench of the memory mode controller against a pin-level memory model
// assumes a pull-up on the shared data wire and weak cells in the upper half of the model
module oms_ctrl_tb
    import oms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [DATA_W-1:0] MAKER_ID = 8'h3e; // arbitrary value
    localparam logic [DATA_W-1:0] PART_ID = 8'h9b; // arbitrary value
    localparam logic [ADDR_W-1:0] EMPTY_ADDR = 15'h0007;
    localparam int STIM_NS = 2;
    logic I_REF_CLK, I_RESET_N, req_valid, ready, rsp_valid;
    logic data_oe_n, select_n, gate_n, prog_en, ident_en, rom_oe_n;
    oms_req_t req;
    oms_rsp_t rsp;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout, rom_q, bus;
    int miscompares, n_compared;
    logic [DATA_W-1:0] exp_mem [int];
    oms_ctrl i_dut (
        .I_REF_CLK(I_REF_CLK),
        .I_RESET_N(I_RESET_N),
        .I_REQ_VALID(req_valid),
        .I_REQ(req),
        .O_REQ_READY(ready),
        .O_RSP_VALID(rsp_valid),
        .O_RSP(rsp),
        .O_ADDR(addr),
        .O_DATA(dout),
        .O_DATA_OE_N(data_oe_n),
        .I_DATA(bus),
        .O_SELECT_N(select_n),
        .O_GATE_N(gate_n),
        .O_PROG_EN(prog_en),
        .O_IDENT_EN(ident_en)
    );
    oms_rom #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) i_rom (
        .i_a(addr),
        .i_d(bus),
        .i_c({select_n, gate_n, prog_en, ident_en}),
        .o_q(rom_q),
        .o_oe_n(rom_oe_n)
    );
    // shared data wire with pull-up
    assign bus = !data_oe_n ? dout : (!rom_oe_n ? rom_q : 8'hff);
    initial begin
        I_REF_CLK = 1'b0;
        forever #(CLK_NS / 2.0) I_REF_CLK = ~I_REF_CLK;
    end
    // both sides never drive the wire together
    always @(negedge I_REF_CLK) begin
        if (I_RESET_N) cmp_pin("single_driver", 1'b1, data_oe_n | rom_oe_n);
    end
    task automatic cmp_pin(input string n, input logic x, input logic v);
        n_compared++;
        if (v !== x) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", n, x, v);
        end
    endtask
    task automatic cmp_rsp(input string n, input oms_rsp_t x, input oms_rsp_t v);
        n_compared++;
        if (v !== x) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", n, x, v);
        end
    endtask
    // one request, held until taken, then its response at mid-cycle
    task automatic issue(input oms_cmd_t c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                         output oms_rsp_t r);
        @(posedge I_REF_CLK);
        #STIM_NS;
        req_valid = 1'b1;
        req = '{cmd: c, addr: a, data: d};
        @(negedge I_REF_CLK);
        while (ready !== 1'b1) @(negedge I_REF_CLK);
        @(posedge I_REF_CLK);
        #STIM_NS;
        req_valid = 1'b0;
        @(negedge I_REF_CLK);
        while (rsp_valid !== 1'b1) @(negedge I_REF_CLK);
        r = rsp;
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #2ms;
        miscompares++;
        report_and_stop();
    end
    initial begin
        oms_rsp_t r;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] old;
        miscompares = 0;
        n_compared = 0;
        I_RESET_N = 1'b0;
        req_valid = 1'b0;
        req = '0;
        void'($urandom(48));
        repeat (12) @(posedge I_REF_CLK);
        #STIM_NS;
        I_RESET_N = 1'b1;
        repeat (3) @(posedge I_REF_CLK);
        @(negedge I_REF_CLK);
        cmp_pin("standby_undriven", 1'b1, rom_oe_n);
        issue(CMD_IDENTIFY, 15'h0000, 8'($urandom), r);
        cmp_rsp("maker_id", '{data: MAKER_ID, ident: MAKER_ID, pulses: '0, fail: 1'b0}, r);
        issue(CMD_IDENTIFY, 15'h0001, 8'($urandom), r);
        cmp_rsp("part_id", '{data: PART_ID, ident: PART_ID, pulses: '0, fail: 1'b0}, r);
        issue(CMD_READ, EMPTY_ADDR, 8'($urandom), r);
        cmp_rsp("erased", '{data: ERASED_BYTE, ident: '0, pulses: '0, fail: 1'b0}, r);
        for (int k = 0; k < 6; k++) begin
            a = {1'(k), 11'($urandom), 3'(k)};
            d = 8'($urandom);
            old = exp_mem.exists(a) ? exp_mem[a] : ERASED_BYTE;
            exp_mem[a] = old & d;
            issue(CMD_PROGRAM, a, d, r);
            cmp_rsp("program", '{data: exp_mem[a], ident: '0, pulses: PCNT_W'(k % 2 + 1), fail: 1'b0}, r);
            issue(CMD_READ, a, 8'($urandom), r);
            cmp_rsp("read", '{data: exp_mem[a], ident: '0, pulses: '0, fail: 1'b0}, r);
            issue(CMD_CHECK, a, d, r);
            cmp_rsp("check_ok", '{data: exp_mem[a], ident: '0, pulses: '0, fail: 1'b0}, r);
            issue(CMD_CHECK, a, d ^ 8'h01, r);
            cmp_rsp("check_bad", '{data: exp_mem[a], ident: '0, pulses: '0, fail: 1'b1}, r);
        end
        @(negedge I_REF_CLK);
        cmp_pin("standby_undriven", 1'b1, rom_oe_n);
        report_and_stop();
    end
endmodule
